// ==== hw/mode_access_pkg.sv ====
// constants, types and carriers for the cpu mode access controller
// assumes one cpu clock domain; memory map splits are fixed at build time
package mode_access_pkg;
   // -------------------------------------------------------------
   // modes, operations, targets
   // -------------------------------------------------------------
   typedef enum logic [2:0] {MODE_BOOT, MODE_TEST, MODE_CL_OS, MODE_SYSTEM, MODE_USER} cpu_mode_t;
   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_EXEC} acc_op_t;
   typedef enum logic [1:0] {MEM_ROM, MEM_EEPROM, MEM_RAM} mem_kind_t;

   // internal state bit encodings (combined with program_status_high)
   localparam logic [1:0] ST_PLAIN = 2'h0;
   localparam logic [1:0] ST_BOOT = 2'h1;
   localparam logic [1:0] ST_TEST = 2'h2;
   localparam logic [1:0] ST_CL_OS = 2'h3;
   localparam logic [1:0] ST_RESET = ST_BOOT;
   // program_status_high bit that selects system over user
   localparam int PSH_SYS_BIT = 7;

   // -------------------------------------------------------------
   // memory partition splits (last address of the dedicated part)
   // -------------------------------------------------------------
   localparam logic [15:0] ROM_TEST_LAST = 16'h1fff;
   localparam logic [15:0] EE_CL_LAST = 16'h03ff;
   localparam logic [15:0] RAM_CL_LAST = 16'h00ff;

   // -------------------------------------------------------------
   // special function register map
   // -------------------------------------------------------------
   localparam logic [7:0] SFR_XLAT_PTR_LO = 8'h80;
   localparam logic [7:0] SFR_XLAT_PTR_HI = 8'h81;
   localparam logic [7:0] SFR_FW_CTRL_LO = 8'h90;
   localparam logic [7:0] SFR_FW_CTRL_HI = 8'h91;
   localparam logic [7:0] SFR_WIN_BASE_LO = 8'h92;
   localparam logic [7:0] SFR_WIN_BASE_HI = 8'h93;
   localparam logic [7:0] SFR_WIN_SIZE_LO = 8'h94;
   localparam logic [7:0] SFR_WIN_SIZE_HI = 8'h95;
   // group boundaries: up to CPU_LAST is general cpu, 80..9f config,
   // a0..af cl os internal, b0..bf test, c0 and up hardware components
   localparam logic [7:0] SFR_CPU_LAST = 8'h7f;
   localparam logic [7:0] SFR_CFG_LAST = 8'h9f;
   localparam logic [7:0] SFR_CLOS_LAST = 8'haf;
   localparam logic [7:0] SFR_TEST_LAST = 8'hbf;
   localparam logic [15:0] REG16_RESET = 16'h0000;
   // firewall control bit positions
   localparam int FW_RAM_WIN_BIT = 0;
   localparam int FW_HW_SFR_BIT = 1;

   // -------------------------------------------------------------
   // carriers
   // -------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic is_sfr;
      acc_op_t op;
      mem_kind_t kind;
      logic [15:0] addr;
   } acc_req_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic ex;
      logic hw;
      logic [15:0] first;
      logic [15:0] last;
   } seg_entry_t;
endpackage

// ==== hw/mode_access_ctrl.sv ====
// cpu mode decoder and memory / register access checker
// assumes requests, status and segment loads come from logic on sys_clk;
// the decision is combinational so a denied access never leaves this block
//
// Summary of operation
// - five modes from status high plus state bits
// - firmware and applications split by partitions, modes
// - configuration writes only in boot, test and system modes
// - user reaches hardware registers only when granted
// - rom split into test and application parts
// - eeprom split into os and application parts
// - ram split into os and application parts
// - read, write, execute checked independently
// - register accesses are read or write, checked
// - segments confined to application partitions
// - translation registers hold segment table pointer
// - firewall registers set os window, register access
// - os disabled: vector call keeps mode
// - os disabled: system reaches the whole ram
// - os disabled: firewall stored but ignored
// - denied read gives zero, denied write dropped
// - up to 64 segments, no rights disables
// - check happens before the target is touched
`timescale 1ns/1ns
`default_nettype none
module mode_access_ctrl
   import mode_access_pkg::*;
#(
   parameter int NUM_SEG = 64
)(
   // clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // configuration and mode events
   input wire logic cl_os_enable,
   input wire logic [7:0] program_status_high,
   input wire logic boot_exit,
   input wire logic test_enter,
   input wire logic vector_call,
   input wire logic cl_os_return,
   input wire logic [15:0] exec_pc,
   // segment table load
   input wire logic seg_wr_en,
   input wire logic [$clog2(NUM_SEG)-1:0] seg_wr_idx,
   input wire mode_access_pkg::seg_entry_t seg_wr_entry,
   // access request from the cpu
   input wire mode_access_pkg::acc_req_t req,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] ext_sfr_rdata,
   // decision and forwarded accesses
   output mode_access_pkg::cpu_mode_t cpu_mode,
   output logic mem_grant,
   output logic sfr_grant,
   output logic mem_fwd_valid,
   output logic sfr_fwd_valid,
   output logic [7:0] sfr_rdata,
   output logic [15:0] xlat_ptr
);
   import mode_access_pkg::*;

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   logic [1:0] state_q;
   seg_entry_t seg_q [NUM_SEG];
   logic [15:0] xlat_ptr_q, fw_ctrl_q, win_base_q, win_size_q;
   logic cfg_mode, own_hit, mem_ok, sfr_ok;
   logic [3:0] data_perm, pc_perm;
   logic [7:0] own_rdata;
   logic [16:0] win_end;

   // or of rights over every enabled segment covering the address
   function automatic logic [3:0] seg_perm(input logic [15:0] a);
      logic [3:0] p;
      p = 4'h0;
      for (int i = 0; i < NUM_SEG; i++)
      begin
         if ((seg_q[i].rd | seg_q[i].wr | seg_q[i].ex | seg_q[i].hw)
             && a >= seg_q[i].first && a <= seg_q[i].last)
            p = p | {seg_q[i].hw, seg_q[i].ex, seg_q[i].wr, seg_q[i].rd};
      end
      return p;
   endfunction

   // mode decode: state bits first, status high picks system or user
   always_comb
   begin
      unique case (state_q)
         ST_BOOT: cpu_mode = MODE_BOOT;
         ST_TEST: cpu_mode = MODE_TEST;
         ST_CL_OS: cpu_mode = MODE_CL_OS;
         ST_PLAIN: cpu_mode = program_status_high[PSH_SYS_BIT] ? MODE_SYSTEM : MODE_USER;
      endcase
   end

   // -------------------------------------------------------------
   // mode state bits
   // -------------------------------------------------------------
   // test entry only from boot; vector calls fall through as plain calls when the os is off
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
         state_q <= ST_RESET;
      else if (state_q == ST_BOOT && test_enter)
         state_q <= ST_TEST;
      else if (state_q == ST_BOOT && boot_exit)
         state_q <= ST_PLAIN;
      else if (state_q == ST_PLAIN && vector_call && cl_os_enable)
         state_q <= ST_CL_OS;
      else if (state_q == ST_CL_OS && cl_os_return)
         state_q <= ST_PLAIN;
   end

   // -------------------------------------------------------------
   // segment table store
   // -------------------------------------------------------------
   // entries whose first address is at or below EE_CL_LAST are stored with no rights
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         for (int i = 0; i < NUM_SEG; i++)
            seg_q[i] <= '0;
      end
      else if (seg_wr_en && (cpu_mode == MODE_BOOT || cpu_mode == MODE_SYSTEM))
      begin
         seg_q[seg_wr_idx] <= seg_wr_entry;
         if (seg_wr_entry.first <= EE_CL_LAST)
            seg_q[seg_wr_idx] <= '0;
      end
   end

   // -------------------------------------------------------------
   // memory check
   // -------------------------------------------------------------
   assign data_perm = seg_perm(req.addr);
   assign pc_perm = seg_perm(exec_pc);
   assign win_end = {1'b0, win_base_q} + {1'b0, win_size_q};

   // per mode, per partition, per operation; rom never written, ram never run
   always_comb
   begin
      logic app_rom, app_ee, app_ram, in_win;
      app_rom = req.addr > ROM_TEST_LAST;
      app_ee = req.addr > EE_CL_LAST;
      // with the os off the whole ram belongs to the application side
      app_ram = !cl_os_enable || req.addr > RAM_CL_LAST;
      in_win = cl_os_enable && fw_ctrl_q[FW_RAM_WIN_BIT]
               && {1'b0, req.addr} >= {1'b0, win_base_q} && {1'b0, req.addr} < win_end;
      mem_ok = 1'b0;
      unique case (req.kind)
         MEM_ROM:
            if (req.op != OP_WRITE)
               unique case (cpu_mode)
                  MODE_BOOT, MODE_CL_OS: mem_ok = !app_rom;
                  MODE_TEST: mem_ok = 1'b1;
                  MODE_SYSTEM: mem_ok = app_rom;
                  MODE_USER: mem_ok = app_rom && (req.op == OP_READ ? data_perm[0] : data_perm[2]);
               endcase
         MEM_EEPROM:
            unique case (cpu_mode)
               MODE_BOOT, MODE_CL_OS: mem_ok = !app_ee;
               MODE_TEST: mem_ok = 1'b1;
               MODE_SYSTEM: mem_ok = app_ee;
               MODE_USER: mem_ok = app_ee && data_perm[req.op];
            endcase
         MEM_RAM:
            if (req.op != OP_EXEC)
               unique case (cpu_mode)
                  MODE_BOOT: mem_ok = !app_ram;
                  MODE_CL_OS: mem_ok = !app_ram || in_win;
                  MODE_TEST: mem_ok = 1'b1;
                  MODE_SYSTEM: mem_ok = app_ram;
                  MODE_USER: mem_ok = app_ram && data_perm[req.op];
               endcase
         default: mem_ok = 1'b0;
      endcase
   end

   // grant is formed in the request cycle, forward only on grant
   assign mem_grant = req.valid && !req.is_sfr && mem_ok;
   assign mem_fwd_valid = mem_grant;

   // -------------------------------------------------------------
   // register check
   // -------------------------------------------------------------
   assign cfg_mode = cpu_mode == MODE_BOOT || cpu_mode == MODE_TEST || cpu_mode == MODE_SYSTEM;

   // groups by address; reads and writes share one decision, exec is refused
   always_comb
   begin
      logic [7:0] a;
      a = req.addr[7:0];
      sfr_ok = 1'b0;
      if (req.op != OP_EXEC)
         unique case (cpu_mode)
            MODE_BOOT, MODE_TEST: sfr_ok = 1'b1;
            MODE_SYSTEM: sfr_ok = a <= SFR_CFG_LAST || a > SFR_TEST_LAST;
            MODE_CL_OS: sfr_ok = a <= SFR_CPU_LAST || (a > SFR_CFG_LAST && a <= SFR_CLOS_LAST)
                                 || (a > SFR_TEST_LAST && fw_ctrl_q[FW_HW_SFR_BIT]);
            MODE_USER: sfr_ok = a <= SFR_CPU_LAST || (a > SFR_TEST_LAST && pc_perm[3]);
         endcase
   end

   assign sfr_grant = req.valid && req.is_sfr && sfr_ok;
   assign own_hit = req.addr[7:0] >= SFR_XLAT_PTR_LO && req.addr[7:0] <= SFR_CFG_LAST;
   assign sfr_fwd_valid = sfr_grant && !own_hit;

   // own registers read back; denied reads are zero
   always_comb
   begin
      unique case (req.addr[7:0])
         SFR_XLAT_PTR_LO: own_rdata = xlat_ptr_q[7:0];
         SFR_XLAT_PTR_HI: own_rdata = xlat_ptr_q[15:8];
         SFR_FW_CTRL_LO: own_rdata = fw_ctrl_q[7:0];
         SFR_FW_CTRL_HI: own_rdata = fw_ctrl_q[15:8];
         SFR_WIN_BASE_LO: own_rdata = win_base_q[7:0];
         SFR_WIN_BASE_HI: own_rdata = win_base_q[15:8];
         SFR_WIN_SIZE_LO: own_rdata = win_size_q[7:0];
         SFR_WIN_SIZE_HI: own_rdata = win_size_q[15:8];
         default: own_rdata = 8'h00;
      endcase
      sfr_rdata = 8'h00;
      if (sfr_grant && req.op == OP_READ)
         sfr_rdata = own_hit ? own_rdata : ext_sfr_rdata;
   end

   // configuration registers; a denied write leaves them untouched
   always_ff @(posedge sys_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         xlat_ptr_q <= REG16_RESET;
         fw_ctrl_q <= REG16_RESET;
         win_base_q <= REG16_RESET;
         win_size_q <= REG16_RESET;
      end
      else if (sfr_grant && req.op == OP_WRITE && cfg_mode)
         unique case (req.addr[7:0])
            SFR_XLAT_PTR_LO: xlat_ptr_q[7:0] <= sfr_wdata;
            SFR_XLAT_PTR_HI: xlat_ptr_q[15:8] <= sfr_wdata;
            SFR_FW_CTRL_LO: fw_ctrl_q[7:0] <= sfr_wdata;
            SFR_FW_CTRL_HI: fw_ctrl_q[15:8] <= sfr_wdata;
            SFR_WIN_BASE_LO: win_base_q[7:0] <= sfr_wdata;
            SFR_WIN_BASE_HI: win_base_q[15:8] <= sfr_wdata;
            SFR_WIN_SIZE_LO: win_size_q[7:0] <= sfr_wdata;
            SFR_WIN_SIZE_HI: win_size_q[15:8] <= sfr_wdata;
            default: ;
         endcase
   end
   assign xlat_ptr = xlat_ptr_q;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   property p_vec_off;
      @(posedge sys_clk) disable iff (sys_rst) vector_call && !cl_os_enable |=> state_q != ST_CL_OS;
   endproperty
   a_vec_off: assert property (p_vec_off) else $error("vector call changed mode with os off");
   property p_sys_ram;
      @(posedge sys_clk) disable iff (sys_rst)
         req.valid && !req.is_sfr && req.kind == MEM_RAM && req.op != OP_EXEC && cpu_mode == MODE_SYSTEM
         && !cl_os_enable |-> mem_grant;
   endproperty
   a_sys_ram: assert property (p_sys_ram) else $error("system ram access refused");
   property p_rom_wr;
      @(posedge sys_clk) disable iff (sys_rst) req.kind == MEM_ROM && req.op == OP_WRITE |-> !mem_grant;
   endproperty
   a_rom_wr: assert property (p_rom_wr) else $error("rom write granted");
   property p_zero;
      @(posedge sys_clk) disable iff (sys_rst) req.is_sfr && !sfr_grant |-> sfr_rdata == 8'h00;
   endproperty
   a_zero: assert property (p_zero) else $error("denied read not zero");
   property p_drop;
      @(posedge sys_clk) disable iff (sys_rst)
         req.is_sfr && req.op == OP_WRITE && !sfr_grant |=> $stable(fw_ctrl_q) && $stable(xlat_ptr_q);
   endproperty
   a_drop: assert property (p_drop) else $error("denied write changed state");
   property p_user_hw;
      @(posedge sys_clk) disable iff (sys_rst)
         req.is_sfr && cpu_mode == MODE_USER && req.addr[7:0] > SFR_TEST_LAST && !pc_perm[3] |-> !sfr_grant;
   endproperty
   a_user_hw: assert property (p_user_hw) else $error("user reached hardware register");
   property p_cfg;
      @(posedge sys_clk) disable iff (sys_rst)
         !$stable(xlat_ptr_q) |-> $past(cpu_mode) inside {MODE_BOOT, MODE_TEST, MODE_SYSTEM};
   endproperty
   a_cfg: assert property (p_cfg) else $error("pointer changed outside config modes");
   property p_fwd;
      @(posedge sys_clk) disable iff (sys_rst) mem_fwd_valid |-> req.valid && mem_ok;
   endproperty
   a_fwd: assert property (p_fwd) else $error("access forwarded without grant");
   property p_no_clos;
      @(posedge sys_clk) disable iff (sys_rst) !cl_os_enable [*2] |-> cpu_mode != MODE_CL_OS || $past(cl_os_enable, 2);
   endproperty
   a_no_clos: assert property (p_no_clos) else $error("os mode entered while disabled");
   c_enter_os: cover property (@(posedge sys_clk) disable iff (sys_rst) state_q == ST_PLAIN ##1 state_q == ST_CL_OS);
   c_user_deny: cover property (@(posedge sys_clk) disable iff (sys_rst) req.valid && cpu_mode == MODE_USER && !mem_grant);
   c_win: cover property (@(posedge sys_clk) disable iff (sys_rst) cpu_mode == MODE_CL_OS && mem_grant && req.addr > RAM_CL_LAST);
endmodule // mode_access_ctrl
`default_nettype wire

// ==== test/cpu_core_model.sv ====
// cpu core model: issues one access per cycle, answers register reads
// assumes the bench calls access() and idle() and nothing else
`timescale 1ns/1ns
`default_nettype none
module cpu_core_model (
   // clock
   input wire logic sys_clk,
   // request and external register data
   output mode_access_pkg::acc_req_t req,
   output logic [7:0] sfr_wdata,
   output logic [7:0] ext_sfr_rdata
);
   import mode_access_pkg::*;
   // start value given at declaration so the toggle process is its only driver
   logic [7:0] noise_q = 8'h3c;
   // unselected data toggles so a stale byte never passes as a read
   always @(posedge sys_clk) noise_q <= ~noise_q;
   assign ext_sfr_rdata = (req.valid && req.is_sfr) ? req.addr[7:0] ^ 8'h5a : noise_q;
   initial
   begin
      req = '0;
      sfr_wdata = 8'h00;
   end
   // changed just after the falling edge, held over the sampling edge
   task automatic access(input acc_req_t r, input logic [7:0] wd);
      @(negedge sys_clk);
      req = r;
      sfr_wdata = wd;
   endtask
   task automatic idle();
      @(negedge sys_clk);
      req = '0;
      sfr_wdata = ~sfr_wdata;
   endtask
endmodule // cpu_core_model
`default_nettype wire

// ==== test/test_cpu_mode_access_control.sv ====
// self-checking bench for the mode access controller
// assumes the core model drives requests; expectations kept in a queue
`timescale 1ns/1ns
`default_nettype none
module test_cpu_mode_access_control;
   import mode_access_pkg::*;
   typedef struct packed {logic mg; logic sg; logic sf; logic [7:0] rd; logic [15:0] ptr;} exp_t;
   logic sys_clk, sys_rst, cl_os_enable, boot_exit, test_enter, vector_call, cl_os_return;
   logic seg_wr_en, mem_grant, sfr_grant, mem_fwd_valid, sfr_fwd_valid;
   logic [7:0] program_status_high, sfr_wdata, ext_sfr_rdata, sfr_rdata, fw_e, plo_e, phi_e;
   logic [15:0] exec_pc, xlat_ptr;
   logic [5:0] seg_wr_idx;
   seg_entry_t seg_wr_entry, seg_e;
   acc_req_t req;
   cpu_mode_t cpu_mode, mode_e;
   int fail_count, n_checks;
   int unsigned seed;
   exp_t exp_q[$];
   exp_t em;
   logic [15:0] atab [10] = '{16'h0000, 16'h00ff, 16'h0100, 16'h03ff, 16'h0400,
                              16'h1fff, 16'h2000, 16'h27ff, 16'h2800, 16'hffff};
   logic [7:0] stab [8] = '{8'h10, 8'h80, 8'h81, 8'h90, 8'ha5, 8'hb3, 8'hc4, 8'hf0};

   mode_access_ctrl dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cl_os_enable(cl_os_enable),
      .program_status_high(program_status_high), .boot_exit(boot_exit), .test_enter(test_enter),
      .vector_call(vector_call), .cl_os_return(cl_os_return), .exec_pc(exec_pc),
      .seg_wr_en(seg_wr_en), .seg_wr_idx(seg_wr_idx), .seg_wr_entry(seg_wr_entry), .req(req),
      .sfr_wdata(sfr_wdata), .ext_sfr_rdata(ext_sfr_rdata), .cpu_mode(cpu_mode),
      .mem_grant(mem_grant), .sfr_grant(sfr_grant), .mem_fwd_valid(mem_fwd_valid),
      .sfr_fwd_valid(sfr_fwd_valid), .sfr_rdata(sfr_rdata), .xlat_ptr(xlat_ptr));
   cpu_core_model cpu (.sys_clk(sys_clk), .req(req), .sfr_wdata(sfr_wdata), .ext_sfr_rdata(ext_sfr_rdata));

   // clock, 40 ns
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // --------------------------------
   // reference decisions
   // --------------------------------
   function automatic logic ded(acc_req_t r);
      case (r.kind)
         MEM_ROM: return r.addr <= ROM_TEST_LAST;
         MEM_EEPROM: return r.addr <= EE_CL_LAST;
         default: return cl_os_enable && r.addr <= RAM_CL_LAST;
      endcase
   endfunction
   function automatic logic exp_mem(acc_req_t r);
      logic ok;
      logic sg;
      ok = !(r.kind == MEM_ROM && r.op == OP_WRITE) && !(r.kind == MEM_RAM && r.op == OP_EXEC);
      sg = r.addr >= seg_e.first && r.addr <= seg_e.last
           && (r.op == OP_READ ? seg_e.rd : r.op == OP_WRITE ? seg_e.wr : seg_e.ex);
      case (mode_e)
         MODE_TEST: return ok;
         MODE_SYSTEM: return ok && !ded(r);
         MODE_USER: return ok && !ded(r) && sg;
         default: return ok && ded(r);
      endcase
   endfunction
   function automatic logic exp_sfr(acc_req_t r);
      logic [7:0] a;
      logic hw;
      a = r.addr[7:0];
      hw = a > SFR_TEST_LAST;
      if (r.op == OP_EXEC) return 1'b0;
      case (mode_e)
         MODE_BOOT, MODE_TEST: return 1'b1;
         // system keeps out of the os internal and test groups
         MODE_SYSTEM: return a <= SFR_CFG_LAST || hw;
         MODE_CL_OS: return a <= SFR_CPU_LAST || (a > SFR_CFG_LAST && a <= SFR_CLOS_LAST)
                            || (hw && fw_e[FW_HW_SFR_BIT]);
         default: return a <= SFR_CPU_LAST
                         || (hw && seg_e.hw && exec_pc >= seg_e.first && exec_pc <= seg_e.last);
      endcase
   endfunction
   // --------------------------------
   // compares and verdict
   // --------------------------------
   task automatic chk_bit(input string what, input logic e, input logic g);
      n_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic chk_word(input string what, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic results();
      if (fail_count == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // answers are combinational, so each sampling edge with a request holds one result
   always @(posedge sys_clk)
   begin
      if (req.valid === 1'b1)
      begin
         em = exp_q.pop_front();
         chk_bit("mem_grant", em.mg, mem_grant);
         chk_bit("mem_fwd_valid", em.mg, mem_fwd_valid);
         chk_bit("sfr_grant", em.sg, sfr_grant);
         chk_bit("sfr_fwd_valid", em.sf, sfr_fwd_valid);
         chk_word("sfr_rdata", {8'h00, em.rd}, {8'h00, sfr_rdata});
         chk_word("xlat_ptr", em.ptr, xlat_ptr);
      end
   end
   // --------------------------------
   // stimulus
   // --------------------------------
   task automatic rnd(input int n);
      acc_req_t r;
      exp_t e;
      logic [7:0] wd, a;
      repeat (n)
      begin
         r.valid = 1'b1;
         r.is_sfr = $urandom_range(1) == 1;
         r.op = acc_op_t'($urandom_range(2));
         r.kind = mem_kind_t'($urandom_range(2));
         r.addr = r.is_sfr ? {8'h00, stab[$urandom_range(7)]} : atab[$urandom_range(9)];
         wd = 8'($urandom);
         cpu.access(r, wd);
         exec_pc = $urandom_range(1) == 1 ? 16'h2100 : 16'h3000;
         a = r.addr[7:0];
         e.sg = r.is_sfr && exp_sfr(r);
         e.mg = !r.is_sfr && exp_mem(r);
         e.sf = e.sg && (a <= SFR_CPU_LAST || a > SFR_CFG_LAST);
         e.rd = !(e.sg && r.op == OP_READ) ? 8'h00 : a == SFR_XLAT_PTR_LO ? plo_e
                : a == SFR_XLAT_PTR_HI ? phi_e : a == SFR_FW_CTRL_LO ? fw_e : a ^ 8'h5a;
         e.ptr = {phi_e, plo_e};
         exp_q.push_back(e);
         if (e.sg && r.op == OP_WRITE && a == SFR_XLAT_PTR_LO) plo_e = wd;
         if (e.sg && r.op == OP_WRITE && a == SFR_XLAT_PTR_HI) phi_e = wd;
         if (e.sg && r.op == OP_WRITE && a == SFR_FW_CTRL_LO) fw_e = wd;
      end
      cpu.idle();
   endtask
   // pulse order: test_enter, boot_exit, vector_call, cl_os_return
   task automatic pulse(input logic [3:0] p, input cpu_mode_t m);
      @(negedge sys_clk);
      {test_enter, boot_exit, vector_call, cl_os_return} = p;
      mode_e = m;
      @(negedge sys_clk);
      {test_enter, boot_exit, vector_call, cl_os_return} = 4'h0;
      chk_word("cpu_mode", {13'h0000, mode_e}, {13'h0000, cpu_mode});
   endtask
   task automatic seg_load(input logic [5:0] i, input seg_entry_t s);
      @(negedge sys_clk);
      {seg_wr_en, seg_wr_idx, seg_wr_entry} = {1'b1, i, s};
      @(negedge sys_clk);
      seg_wr_en = 1'b0;
   endtask
   task automatic do_reset();
      sys_rst = 1'b1;
      repeat (20) @(negedge sys_clk);
      sys_rst = 1'b0;
      {mode_e, fw_e, plo_e, phi_e, seg_e} = {MODE_BOOT, 24'h000000, 36'h0};
      chk_word("cpu_mode", {13'h0000, mode_e}, {13'h0000, cpu_mode});
   endtask
   initial
   begin
      {sys_rst, cl_os_enable, program_status_high, exec_pc} = {2'b11, 8'h80, 16'h0000};
      {test_enter, boot_exit, vector_call, cl_os_return, seg_wr_en} = 5'h00;
      {seg_wr_idx, seg_wr_entry} = '0;
      {fail_count, n_checks} = {32'd0, 32'd0};
      seed = $urandom(2);
      do_reset();
      rnd(60);
      do_reset();
      pulse(4'b1100, MODE_TEST);
      rnd(60);
      do_reset();
      pulse(4'b0100, MODE_SYSTEM);
      seg_e = '{1'b1, 1'b0, 1'b1, 1'b1, 16'h2000, 16'h27ff};
      seg_load(6'h3f, seg_e);
      seg_load(6'h01, '{1'b1, 1'b1, 1'b0, 1'b1, 16'h0300, 16'h0fff});
      rnd(150);
      pulse(4'b0010, MODE_CL_OS);
      rnd(80);
      pulse(4'b0001, MODE_SYSTEM);
      cl_os_enable = 1'b0;
      pulse(4'b0010, MODE_SYSTEM);
      rnd(60);
      program_status_high = 8'h00;
      mode_e = MODE_USER;
      seg_load(6'h02, '{1'b1, 1'b1, 1'b1, 1'b1, 16'h0400, 16'hffff});
      chk_word("cpu_mode", {13'h0000, mode_e}, {13'h0000, cpu_mode});
      rnd(150);
      results();
   end
   // about 640 cycles expected, cut off well beyond
   initial
   begin
      #(40 * 3000);
      fail_count++;
      results();
   end
endmodule // test_cpu_mode_access_control
`default_nettype wire
